// File: core/sppd_map.svh
// Register offsets, field positions, reset values and timing for the stepper port drive.
`ifndef SPPD_MAP_SVH
`define SPPD_MAP_SVH
`define SPPD_A_CTRL 12'h000
`define SPPD_A_STEP 12'h004
`define SPPD_A_AUX 12'h008
`define SPPD_A_INMAP 12'h00C
`define SPPD_A_OUTMAP 12'h010
`define SPPD_A_PWORD 12'h014
`define SPPD_A_STATUS 12'h018
`define SPPD_A_PULSE 12'h01C
`define SPPD_A_SPDLY 12'h020
`define SPPD_A_INPUTS 12'h024
`define SPPD_A_SETUP 12'h028
`define SPPD_C_MODE 0
`define SPPD_C_ESTOP_SEL 1
`define SPPD_C_ESTOP_INV 4
`define SPPD_C_DIR_INV 8
`define SPPD_C_CTRL_RST 32'h0000_0001
`define SPPD_INMAP_RST 32'h0000_3210
`define SPPD_OUTMAP_RST 32'h0000_3210
`define SPPD_PWORD_RST 8'hFF
`define SPPD_PULSE_MIN_NS 10000
`define SPPD_MS_NS 1000000
`define SPPD_CLK_NS 10
`define SPPD_SETUP_RST 16'h0064
`endif

// File: core/sppd_pkg.sv
// Types shared by the stepper port drive.
package sppd_pkg;
  typedef enum logic [1:0] {
    SPPD_IDLE,
    SPPD_SETUP,
    SPPD_PULSE
  } sppd_state_t;
endpackage

// File: core/sppd_pulse_gen.sv
// One timed output pulse: setup wait, then a high pulse of programmed length.
`timescale 1ns/10ps
`include "sppd_map.svh"
module sppd_pulse_gen #(
  parameter int CW = 20
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Request and timing.
  input wire logic start,
  input wire logic [CW-1:0] setup_cycles,
  input wire logic [CW-1:0] pulse_cycles,
  // Outputs.
  output logic busy,
  output logic pulse_q
);
  sppd_pkg::sppd_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic pulse_d;

  initial begin
    if (CW < 11) $error("sppd_pulse_gen: counter too narrow for minimum pulse");
  end

  // Setup phase keeps data stable before the edge; pulse phase holds the pulse.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    pulse_d = 1'b0;
    case (state_q)
      sppd_pkg::SPPD_IDLE: begin
        if (start) begin
          state_d = sppd_pkg::SPPD_SETUP;
          cnt_d = setup_cycles;
        end
      end
      sppd_pkg::SPPD_SETUP: begin
        if (cnt_q <= CW'(1)) begin
          state_d = sppd_pkg::SPPD_PULSE;
          cnt_d = pulse_cycles;
          pulse_d = 1'b1;
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
      sppd_pkg::SPPD_PULSE: begin
        if (cnt_q <= CW'(1)) begin
          state_d = sppd_pkg::SPPD_IDLE;
        end else begin
          cnt_d = cnt_q - CW'(1);
          pulse_d = 1'b1;
        end
      end
      default: state_d = sppd_pkg::SPPD_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= sppd_pkg::SPPD_IDLE;
      cnt_q <= '0;
      pulse_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pulse_q <= pulse_d;
    end
  end

  assign busy = (state_q != sppd_pkg::SPPD_IDLE);
endmodule

// File: core/sppd_top.sv
// Stepper drive over a parallel port: clock/direction and phase-current variants.
//
// Contract
// - Clock/direction mode gives four axes each a direction and step-clock output.
// - Aux outputs default to spindle, coolant, current reduction and job running.
// - Four assignable inputs default to X, Y, Z reference and probe; one spare.
// - Five inputs and four aux outputs are remappable, default mapping at reset; the aux remap acts in clock/direction mode only.
// - Phase-current word bits 1-2 hold phase A code: 11 off,01 20%,10 60%,00 full.
// - Bit 3 is phase A direction; bits 4-5 phase B code, same encoding.
// - Bit 6 is phase B direction; bits 7-8 select motor: 00 X, 10 Y, 01 Z.
// - Strobe pulses once word is stable; card latches data on that strobe.
// - Phase-current mode reads all references on one input; coolant and spindle aux.
// - An emergency-stop input, when unsafe, forces all outputs inactive.
// - Step pulses last at least 10 us, lengthenable by a setting.
// - A per-axis bit inverts the direction output polarity.
// - After spindle switch-on, motion waits a programmable delay in milliseconds; only step writes are held off, phase-word writes are not.
`timescale 1ns/10ps
`include "sppd_map.svh"
module sppd_top #(
  parameter int CW = 20,
  parameter int SPDLY_CYCLES_PER_MS = `SPPD_MS_NS / `SPPD_CLK_NS
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port data pins 2..9.
  output logic [7:0] port_data,
  // Port control pins 1, 14, 16, 17.
  output logic [3:0] port_aux,
  // Port input pins 10, 11, 12, 13, 15.
  input wire logic [4:0] port_in
);
  localparam int PULSE_MIN_CYC = (`SPPD_PULSE_MIN_NS + `SPPD_CLK_NS - 1) / `SPPD_CLK_NS;

  initial begin
    if (CW < 11 || CW > 31) $error("sppd_top: CW out of range");
    if (SPDLY_CYCLES_PER_MS < 1) $error("sppd_top: ms tick must be positive");
  end

  // Remap decode: pick the source selected by a 3-bit field.
  function automatic logic pick5(input logic [4:0] v, input logic [2:0] sel);
    pick5 = (sel < 3'h5) ? v[sel] : 1'b0;
  endfunction

  // Input synchroniser: three stages, change accepted when stages two and three agree.
  logic [4:0] in_s1_q, in_s2_q, in_s3_q, in_f_q, in_f_d;
  always_comb begin
    in_f_d = in_f_q;
    for (int i = 0; i < 5; i++) begin
      if (in_s2_q[i] == in_s3_q[i]) in_f_d[i] = in_s3_q[i];
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      in_s1_q <= '0;
      in_s2_q <= '0;
      in_s3_q <= '0;
      in_f_q <= '0;
    end else begin
      in_s1_q <= port_in;
      in_s2_q <= in_s1_q;
      in_s3_q <= in_s2_q;
      in_f_q <= in_f_d;
    end
  end

  // Register file.
  logic [31:0] ctrl_q, ctrl_d, inmap_q, inmap_d, outmap_q, outmap_d;
  logic [3:0] aux_q, aux_d;
  logic [7:0] pword_q, pword_d;
  logic [CW-1:0] pulse_q, pulse_d, setup_q, setup_d;
  logic [15:0] spdly_q, spdly_d;
  logic [3:0] step_req_q, step_req_d, step_dir_q, step_dir_d;
  logic strobe_req_q, strobe_req_d;
  logic [31:0] rdata_d;
  logic wr, rd, hit;
  logic [3:0] ax_busy;
  logic [3:0] ax_pulse;
  logic st_busy, st_pulse, estop, spin_wait;
  logic [3:0] in_func;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign hit = (paddr <= `SPPD_A_SETUP) && (paddr[1:0] == 2'b00);
  assign pslverr = psel && penable && !hit;

  // Emergency input chosen by ctrl; inactive level configurable.
  assign estop = pick5(in_f_q, ctrl_q[`SPPD_C_ESTOP_SEL +: 3]) ^ ctrl_q[`SPPD_C_ESTOP_INV];

  // Register writes and step/strobe request capture.
  always_comb begin
    ctrl_d = ctrl_q;
    inmap_d = inmap_q;
    outmap_d = outmap_q;
    aux_d = aux_q;
    pword_d = pword_q;
    pulse_d = pulse_q;
    setup_d = setup_q;
    spdly_d = spdly_q;
    step_dir_d = step_dir_q;
    strobe_req_d = strobe_req_q && st_busy;
    step_req_d = step_req_q & ~(ax_busy & ~ax_pulse);
    for (int a = 0; a < 4; a++) begin
      if (ax_busy[a]) step_req_d[a] = 1'b0;
    end
    if (wr && hit) begin
      case (paddr)
        `SPPD_A_CTRL: ctrl_d = pwdata;
        `SPPD_A_INMAP: inmap_d = pwdata;
        `SPPD_A_OUTMAP: outmap_d = pwdata;
        `SPPD_A_AUX: aux_d = pwdata[3:0];
        `SPPD_A_PULSE: pulse_d = (pwdata[CW-1:0] < CW'(PULSE_MIN_CYC)) ?
                                 CW'(PULSE_MIN_CYC) : pwdata[CW-1:0];
        `SPPD_A_SETUP: setup_d = (pwdata[CW-1:0] == '0) ? CW'(1) : pwdata[CW-1:0];
        `SPPD_A_SPDLY: spdly_d = pwdata[15:0];
        `SPPD_A_PWORD: begin
          if (!st_busy && !estop) begin
            pword_d = pwdata[7:0];
            strobe_req_d = ctrl_q[`SPPD_C_MODE];
          end
        end
        `SPPD_A_STEP: begin
          for (int a = 0; a < 4; a++) begin
            if (pwdata[a] && !ax_busy[a] && !estop && !spin_wait) begin
              step_req_d[a] = 1'b1;
              step_dir_d[a] = pwdata[4 + a];
            end
          end
        end
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= `SPPD_C_CTRL_RST;
      inmap_q <= `SPPD_INMAP_RST;
      outmap_q <= `SPPD_OUTMAP_RST;
      aux_q <= '0;
      pword_q <= `SPPD_PWORD_RST;
      pulse_q <= CW'(PULSE_MIN_CYC);
      setup_q <= CW'(`SPPD_SETUP_RST);
      spdly_q <= '0;
      step_dir_q <= '0;
      step_req_q <= '0;
      strobe_req_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      inmap_q <= inmap_d;
      outmap_q <= outmap_d;
      aux_q <= aux_d;
      pword_q <= pword_d;
      pulse_q <= pulse_d;
      setup_q <= setup_d;
      spdly_q <= spdly_d;
      step_dir_q <= step_dir_d;
      step_req_q <= step_req_d;
      strobe_req_q <= strobe_req_d;
    end
  end

  // Spindle start delay: counts down ms after aux function 0 (spindle) turns on.
  logic spin_prev_q, spin_prev_d;
  logic [15:0] ms_left_q, ms_left_d;
  logic [CW-1:0] tick_q, tick_d;
  assign spin_wait = (ms_left_q != '0);
  always_comb begin
    spin_prev_d = aux_q[0];
    ms_left_d = ms_left_q;
    tick_d = tick_q;
    if (aux_q[0] && !spin_prev_q) begin
      ms_left_d = spdly_q;
      tick_d = CW'(SPDLY_CYCLES_PER_MS - 1);
    end else if (spin_wait) begin
      if (tick_q == '0) begin
        ms_left_d = ms_left_q - 16'h0001;
        tick_d = CW'(SPDLY_CYCLES_PER_MS - 1);
      end else begin
        tick_d = tick_q - CW'(1);
      end
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      spin_prev_q <= 1'b0;
      ms_left_q <= '0;
      tick_q <= '0;
    end else begin
      spin_prev_q <= spin_prev_d;
      ms_left_q <= ms_left_d;
      tick_q <= tick_d;
    end
  end

  // Four step pulse generators and the strobe generator.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_axis
      sppd_pulse_gen #(.CW(CW)) u_step (
        .clk(clk),
        .srst(srst),
        .start(step_req_q[g] && !ctrl_q[`SPPD_C_MODE]),
        .setup_cycles(setup_q),
        .pulse_cycles(pulse_q),
        .busy(ax_busy[g]),
        .pulse_q(ax_pulse[g])
      );
    end
  endgenerate
  sppd_pulse_gen #(.CW(CW)) u_strobe (
    .clk(clk),
    .srst(srst),
    .start(strobe_req_q && !st_busy),
    .setup_cycles(setup_q),
    .pulse_cycles(pulse_q),
    .busy(st_busy),
    .pulse_q(st_pulse)
  );

  // Input function decode: ref X, ref Y, ref Z, probe from remap fields, refs from input 1 in phase-current mode.
  always_comb begin
    for (int f = 0; f < 4; f++) begin
      in_func[f] = pick5(in_f_q, inmap_q[4*f +: 3]);
    end
    if (ctrl_q[`SPPD_C_MODE]) in_func[2:0] = {3{in_f_q[1]}};
  end

  // Pin drive; direction inversion applied before the pin, all off on emergency.
  logic [7:0] data_d, data_q;
  logic [3:0] auxo_d, auxo_q;
  logic [3:0] dir_pin;
  always_comb begin
    dir_pin = step_dir_q ^ ctrl_q[`SPPD_C_DIR_INV +: 4];
    data_d = '0;
    auxo_d = '0;
    if (ctrl_q[`SPPD_C_MODE]) begin
      data_d = pword_q;
      auxo_d = {1'b0, aux_q[0], aux_q[1], st_pulse};
    end else begin
      for (int a = 0; a < 4; a++) begin
        data_d[2*a] = dir_pin[a];
        data_d[2*a+1] = ax_pulse[a];
      end
      for (int o = 0; o < 4; o++) begin
        auxo_d[o] = aux_q[outmap_q[4*o +: 2]];
      end
    end
    if (estop) begin
      data_d = '0;
      auxo_d = '0;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      data_q <= '0;
      auxo_q <= '0;
    end else begin
      data_q <= data_d;
      auxo_q <= auxo_d;
    end
  end
  assign port_data = data_q;
  assign port_aux = auxo_q;

  // Read mux.
  always_comb begin
    case (paddr)
      `SPPD_A_CTRL: rdata_d = ctrl_q;
      `SPPD_A_STEP: rdata_d = {24'h000000, step_dir_q, ax_busy};
      `SPPD_A_AUX: rdata_d = {28'h0000000, aux_q};
      `SPPD_A_INMAP: rdata_d = inmap_q;
      `SPPD_A_OUTMAP: rdata_d = outmap_q;
      `SPPD_A_PWORD: rdata_d = {24'h000000, pword_q};
      `SPPD_A_STATUS: rdata_d = {26'h0, spin_wait, estop, st_busy, 1'b0, |ax_busy, 1'b0};
      `SPPD_A_PULSE: rdata_d = 32'(pulse_q);
      `SPPD_A_SPDLY: rdata_d = {16'h0000, spdly_q};
      `SPPD_A_INPUTS: rdata_d = {23'h0, in_func, in_f_q};
      `SPPD_A_SETUP: rdata_d = 32'(setup_q);
      default: rdata_d = 32'h00000000;
    endcase
  end
  assign prdata = rd ? rdata_d : 32'h00000000;

  // Length of the running axis 0 pulse, so the width check sees the pin, not the setting.
  logic [CW-1:0] run0_q, run0_d;
  always_comb begin
    run0_d = ax_pulse[0] ? run0_q + CW'(1) : '0;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      run0_q <= '0;
    end else begin
      run0_q <= run0_d;
    end
  end

  // Strobe only follows a settled word.
  chk_strobe_stable: assert property (@(posedge clk) disable iff (srst)
    $rose(port_aux[0]) && ctrl_q[0] |-> $stable(port_data)) else $error("strobe with moving data");
  chk_estop_off: assert property (@(posedge clk) disable iff (srst)
    estop |=> (port_data == 8'h00 && port_aux == 4'h0)) else $error("outputs live in estop");
  chk_pulse_min: assert property (@(posedge clk) disable iff (srst)
    $fell(ax_pulse[0]) |-> run0_q >= CW'(PULSE_MIN_CYC)) else $error("short step");
  chk_spin_block: assert property (@(posedge clk) disable iff (srst)
    spin_wait |=> !$rose(step_req_q[0])) else $error("step during spindle delay");
  chk_dir_inv: assert property (@(posedge clk) disable iff (srst)
    !ctrl_q[0] && !estop |=> port_data[0] == $past(dir_pin[0])) else $error("dir pin wrong");
  chk_word_out: assert property (@(posedge clk) disable iff (srst)
    ctrl_q[0] && !estop |=> port_data == $past(pword_q)) else $error("word not on pins");
  chk_strobe_once: assert property (@(posedge clk) disable iff (srst)
    $rose(st_pulse) |-> ##1 st_pulse [*1] ##0 $past(st_busy)) else $error("strobe idle");
  chk_ref_shared: assert property (@(posedge clk) disable iff (srst)
    ctrl_q[0] |-> in_func[2:0] == {3{in_f_q[1]}}) else $error("shared ref");
endmodule

// File: test/sppd_card_model.sv
// Behavioural driver card at the port pins: latches phase words and times step pulses.
`timescale 1ns/10ps
module sppd_card_model (
  // Clock and the variant the bench has selected.
  input wire logic clk,
  input wire logic mode_phase,
  // Port pins seen from the card.
  input wire logic [7:0] port_data,
  input wire logic [3:0] port_aux
);
  logic [7:0] word_q [3];
  logic [3:0] dir_seen = 4'h0;
  logic [7:0] prev_data = 8'h00;
  logic prev_stb = 1'b0;
  int steps [4] = '{default: 0};
  int width [4] = '{default: 0};
  int run [4] = '{default: 0};
  int strobes = 0;
  int bad = 0;

  // The card samples on the clock; a value that moves at a live edge is unreliable.
  always @(posedge clk) begin
    for (int a = 0; a < 4; a++) begin
      if (!mode_phase && port_data[2*a+1]) begin
        if (port_data[2*a] !== prev_data[2*a]) bad++;
        if (!prev_data[2*a+1]) begin
          steps[a]++;
          dir_seen[a] = port_data[2*a];
          run[a] = 1;
        end else begin
          run[a]++;
        end
      end else if (!mode_phase && prev_data[2*a+1]) begin
        width[a] = run[a];
      end
    end
    if (mode_phase && port_aux[0]) begin
      if (port_data !== prev_data) bad++;
      if (!prev_stb) begin
        strobes++;
        // Motor select reads bit 6 then bit 7: 00 first, 10 second, 01 third motor.
        case ({port_data[6], port_data[7]})
          2'b00: word_q[0] = port_data;
          2'b10: word_q[1] = port_data;
          2'b01: word_q[2] = port_data;
          default: bad++;
        endcase
      end
    end
    prev_data = port_data;
    prev_stb = port_aux[0];
  end
endmodule

// File: test/sppd_top_tb.sv
// Self-checking bench for the stepper port drive.
`timescale 1ns/10ps
`include "sppd_map.svh"
module sppd_top_tb;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, err, mode_phase;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] port_data;
  logic [3:0] port_aux;
  logic [4:0] port_in;
  int fails = 0;
  int num_checks = 0;

  sppd_top #(.CW(20), .SPDLY_CYCLES_PER_MS(10)) u_sppd_top (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_data(port_data), .port_aux(port_aux), .port_in(port_in)
  );
  sppd_card_model u_sppd_card_model (
    .clk(clk), .mode_phase(mode_phase), .port_data(port_data), .port_aux(port_aux)
  );

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Prints the counts and the verdict, then stops the run.
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high at a rising edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      end_of_test();
    end
  endtask

  // Polls one status bit until it reads the wanted value, within a bound.
  task wait_stat(input int b, input logic v, input int lim);
    int n;
    n = 0;
    do begin
      apb(1'b0, `SPPD_A_STATUS, 32'h0);
      n++;
    end while (rd[b] !== v && n < lim);
    if (rd[b] !== v) begin
      fails++;
      end_of_test();
    end
    // The pins and the card trail the status bit by a cycle or two.
    repeat (3) @(posedge clk);
  endtask

  task automatic t_reset;
    logic [11:0] a [4] = '{`SPPD_A_CTRL, `SPPD_A_INMAP, `SPPD_A_OUTMAP, `SPPD_A_SETUP};
    logic [31:0] e [4] = '{32'h0000_0001, 32'h0000_3210, 32'h0000_3210, 32'h0000_0064};
    chk(port_data, 32'h0, "data at reset");
    chk(port_aux, 32'h0, "aux at reset");
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, a[i], 32'h0);
      chk(rd, e[i], "reset value");
    end
    apb(1'b1, 12'hFFC, 32'hFFFF_FFFF);
    chk(err, 1'b1, "unmapped write");
    $display("test reset done");
  endtask

  task automatic t_phase;
    logic [7:0] w [3] = '{8'h07, 8'h6A, 8'h98};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `SPPD_A_PWORD, {24'h0, w[i]});
      wait_stat(3, 1'b0, 500);
      chk(u_sppd_card_model.word_q[i], w[i], "card word");
    end
    chk(u_sppd_card_model.strobes, 32'h3, "strobe count");
    $display("test phase done");
  endtask

  task t_step;
    apb(1'b1, `SPPD_A_CTRL, 32'h0);
    mode_phase <= 1'b0;
    apb(1'b1, `SPPD_A_PULSE, 32'h0000_03E8);
    apb(1'b1, `SPPD_A_STEP, 32'h0000_0011);
    wait_stat(1, 1'b0, 1000);
    chk(u_sppd_card_model.steps[0], 32'h1, "one step");
    chk(u_sppd_card_model.dir_seen[0], 1'b1, "dir plain");
    chk(u_sppd_card_model.width[0] >= 1000, 1'b1, "pulse width");
    apb(1'b1, `SPPD_A_CTRL, 32'h0000_0100);
    apb(1'b1, `SPPD_A_STEP, 32'h0000_00FF);
    wait_stat(1, 1'b0, 1000);
    chk(u_sppd_card_model.dir_seen, 4'hE, "dir inverted");
    for (int i = 0; i < 4; i++) begin
      chk(u_sppd_card_model.steps[i], i == 0 ? 2 : 1, "axis steps");
    end
    chk(u_sppd_card_model.bad, 32'h0, "setup order");
    $display("test step done");
  endtask

  task t_spindle;
    apb(1'b1, `SPPD_A_SPDLY, 32'h2);
    apb(1'b1, `SPPD_A_AUX, 32'h1);
    apb(1'b1, `SPPD_A_STEP, 32'h0000_0001);
    apb(1'b0, `SPPD_A_STATUS, 32'h0);
    chk(rd[5], 1'b1, "spindle wait");
    wait_stat(5, 1'b0, 40);
    chk(u_sppd_card_model.steps[0], 32'h2, "step refused");
    chk(port_aux[0], 1'b1, "spindle pin");
    apb(1'b1, `SPPD_A_OUTMAP, 32'h0);
    repeat (3) @(posedge clk);
    chk(port_aux, 32'hF, "aux remapped");
    $display("test spindle done");
  endtask

  task t_estop_inputs;
    int n;
    port_in <= 5'h01;
    wait_stat(4, 1'b1, 20);
    apb(1'b1, `SPPD_A_STEP, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk(port_aux, 32'h0, "aux in estop");
    chk(port_data, 32'h0, "data in estop");
    chk(u_sppd_card_model.steps[0], 32'h2, "no step in estop");
    port_in <= 5'h1E;
    wait_stat(4, 1'b0, 20);
    n = 0;
    do begin
      apb(1'b0, `SPPD_A_INPUTS, 32'h0);
      n++;
    end while (rd[4:0] !== 5'h1E && n < 30);
    chk(rd[4:0], 5'h1E, "input pins");
    chk(rd[8:5], 4'hE, "input functions");
    apb(1'b1, `SPPD_A_INMAP, 32'h0000_4444);
    apb(1'b0, `SPPD_A_INPUTS, 32'h0);
    chk(rd[8:5], 4'hF, "inputs remapped");
    apb(1'b1, `SPPD_A_INMAP, 32'h0000_3210);
    apb(1'b1, `SPPD_A_CTRL, 32'h1);
    mode_phase <= 1'b1;
    apb(1'b0, `SPPD_A_INPUTS, 32'h0);
    chk(rd[8:5], 4'hF, "shared reference");
    $display("test estop done");
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    port_in = 5'h00;
    mode_phase = 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_phase();
    t_step();
    t_spindle();
    t_estop_inputs();
    end_of_test();
  end
endmodule
